// ==== include/drive_cmd_pkg.sv ====
// Constants, types and field layout for the drive command/state block
// Function
// - Bit 10 low ignores whole command word
// - Bits 01:00 pick one of four presets
// - Bit 02 low: DC brake and stop
// - Bit 03 low: output off, motor coasts
// - Bit 03 high: start only if all allow
// - Bit 04 low: quick-stop ramp to standstill
// - Bit 05 low freezes frequency; only inputs trim
// - Frozen: stop only by coast or brake
// - Bit 06 low ramp stop; high allows start
// - Trip reset only on bit 07 rising edge
// - Bit 08 high selects jog speed
// - Bit 09 selects ramp set one or two
// - Bits 11,12 drive relays if function selected
// - Bits 14:13 pick set-up when multi-set-up
// - Bit 15 reverses if source bus/and/or
// - State bits 03,04,06: trip, error, lock
// - State bit 08: speed equals reference
// - State bit 09 low refuses bus control
// - State bits 10,11: in limits, operating
// - State bits 12-15: temp, volts, torque, timer
// - Link loss forces state word zero
// - Speed values: signed, 16384 is 100 %
package drive_cmd_pkg;
    localparam int CW_PRESET_LO  = 0;
    localparam int CW_PRESET_HI  = 1;
    localparam int CW_NO_BRAKE   = 2;
    localparam int CW_NO_COAST   = 3;
    localparam int CW_NO_QSTOP   = 4;
    localparam int CW_NO_HOLD    = 5;
    localparam int CW_START      = 6;
    localparam int CW_RESET      = 7;
    localparam int CW_JOG        = 8;
    localparam int CW_RAMP2      = 9;
    localparam int CW_VALID      = 10;
    localparam int CW_RELAY1     = 11;
    localparam int CW_RELAY2     = 12;
    localparam int CW_SETUP_LO   = 13;
    localparam int CW_SETUP_HI   = 14;
    localparam int CW_REVERSE    = 15;

    localparam int SW_CTRL_READY = 0;
    localparam int SW_DRV_READY  = 1;
    localparam int SW_ENABLE     = 2;
    localparam int SW_TRIP       = 3;
    localparam int SW_ERROR      = 4;
    localparam int SW_RESERVED   = 5;
    localparam int SW_TRIP_LOCK  = 6;
    localparam int SW_WARNING    = 7;
    localparam int SW_AT_REF     = 8;
    localparam int SW_BUS_CTRL   = 9;
    localparam int SW_IN_LIMIT   = 10;
    localparam int SW_RUNNING    = 11;
    localparam int SW_OVERTEMP   = 12;
    localparam int SW_VOLTAGE    = 13;
    localparam int SW_TORQUE     = 14;
    localparam int SW_TIMER      = 15;

    // Command word after reset: all stop bits asserted, data invalid
    localparam logic [15:0] COMMAND_WORD_RESET = 16'h0000;
    localparam logic [15:0] SPEED_FULL_SCALE   = 16'h4000;

    // Reversing source selection
    localparam logic [1:0] REV_DIGITAL = 2'h0;
    localparam logic [1:0] REV_BUS     = 2'h1;
    localparam logic [1:0] REV_AND     = 2'h2;
    localparam logic [1:0] REV_OR      = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_RUN   = 5'b00010,
        ST_HOLD  = 5'b00100,
        ST_STOP  = 5'b01000,
        ST_COAST = 5'b10000
    } motion_state_t;

    typedef enum logic [1:0] {
        STOP_NONE  = 2'h0,
        STOP_RAMP  = 2'h1,
        STOP_QUICK = 2'h2,
        STOP_BRAKE = 2'h3
    } stop_kind_t;

    // Configuration settings held by the drive
    typedef struct packed {
        logic [1:0] rev_source;
        logic       relay1_sel_bus;
        logic       relay2_sel_bus;
        logic       multi_setup;
    } drive_cfg_t;

    // Conditions reported by the power stage and control unit
    typedef struct packed {
        logic ctrl_ready;
        logic drv_ready;
        logic tripped;
        logic error_no_trip;
        logic trip_locked;
        logic warning;
        logic local_stop;
        logic local_ref;
        logic overtemp_auto;
        logic dc_link_bad;
        logic torque_over;
        logic thermal_over;
        logic link_lost;
    } drive_status_t;

    // Digital input functions read alongside the command word
    typedef struct packed {
        logic speed_up;
        logic slow_down;
        logic dc_brake;
        logic coast;
        logic reset_coast;
        logic start;
        logic reverse;
    } din_func_t;

    // Actions delivered to the motor control core
    typedef struct packed {
        logic       outputs_on;
        logic       run;
        stop_kind_t stop_kind;
        logic       hold;
        logic       trim_up;
        logic       trim_down;
        logic       jog;
        logic       ramp_set2;
        logic [1:0] preset_sel;
        logic [1:0] setup_sel;
        logic       reverse;
        logic       relay1;
        logic       relay2;
    } drive_action_t;
endpackage

// ==== tb/bus_master_model.sv ====
// Fieldbus master model issuing command words
`timescale 1ns/100ps
module bus_master_model (
    // Clock
    input  wire logic core_clk,
    // Command side
    output logic      cmd_write,
    output logic [15:0] command_word,
    output logic [15:0] bus_speed_ref
);
    initial begin
        cmd_write = 1'b0;
        command_word = 16'h0000;
        bus_speed_ref = 16'h0000;
    end
    // Released data is inverted so a stale word never passes for fresh
    task automatic send(input logic [15:0] w, input logic [15:0] r);
        @(posedge core_clk);
        #1;
        cmd_write = 1'b1;
        command_word = w;
        bus_speed_ref = r;
        @(posedge core_clk);
        #1;
        cmd_write = 1'b0;
        command_word = ~w;
        bus_speed_ref = ~r;
    endtask
endmodule

// ==== tb/drive_bus_command_status_word_bench.sv ====
// Self-checking bench for the drive command/state block
`timescale 1ns/100ps
module drive_bus_command_status_word_bench;
    import drive_cmd_pkg::*;
    logic          core_clk, reset, cmd_write, ramp_done, trip_reset;
    logic [15:0]   command_word, bus_speed_ref, sw, afv, speed_ref_out;
    logic [15:0]   output_freq, lo_lim, hi_lim;
    drive_cfg_t    cfg;
    drive_status_t status;
    din_func_t     din_pins;
    drive_action_t action;
    int            n_fail, checks_done, cycles, n_pulse, i;
    logic [15:0]   stop_w[3] = '{16'h047b, 16'h046f, 16'h043f};
    stop_kind_t    stop_k[3] = '{STOP_BRAKE, STOP_QUICK, STOP_RAMP};
    bus_master_model bus_master_model_i (.core_clk(core_clk),
        .cmd_write(cmd_write), .command_word(command_word),
        .bus_speed_ref(bus_speed_ref));
    drive_bus_command_status_word drive_bus_command_status_word_i (
        .core_clk(core_clk), .reset(reset), .cmd_write(cmd_write),
        .command_word(command_word), .bus_speed_ref(bus_speed_ref),
        .state_report_word(sw), .actual_output_frequency_value(afv),
        .speed_ref_out(speed_ref_out), .cfg(cfg), .status(status),
        .output_freq(output_freq), .speed_low_limit(lo_lim),
        .speed_high_limit(hi_lim), .ramp_done(ramp_done),
        .din_pins(din_pins), .action(action), .trip_reset(trip_reset));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic snd(input logic [15:0] w, input logic [15:0] r);
        bus_master_model_i.send(w, r);
        wt(4);
    endtask
    // Hang guard: far beyond the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (trip_reset === 1'b1)
            n_pulse++;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        reset = 1'b1;
        ramp_done = 1'b1;
        output_freq = 16'h0000;
        lo_lim = 16'h0000;
        hi_lim = 16'h4000;
        cfg = '{REV_BUS, 1'b1, 1'b1, 1'b1};
        status = '0;
        status.ctrl_ready = 1'b1;
        din_pins = '0;
        repeat (6) @(posedge core_clk);
        #1 reset = 1'b0;
        wt(2);
        chk(sw[SW_RESERVED], 16'h0000);
        snd(16'h007f, 16'h1234);
        chk(speed_ref_out, 16'h0000);
        chk(action.run, 16'h0000);
        snd(16'h047f, 16'h4000);
        chk(speed_ref_out, SPEED_FULL_SCALE);
        chk(action.run, 16'h0001);
        for (i = 0; i < 4; i++) begin
            snd(16'h047c | 16'(i), 16'hc000);
            chk(action.preset_sel, 16'(i));
        end
        chk(speed_ref_out, 16'hc000);
        for (i = 0; i < 3; i++) begin
            ramp_done = 1'b0;
            snd(stop_w[i], 16'h0000);
            chk(action.stop_kind, stop_k[i]);
            ramp_done = 1'b1;
            snd(16'h047f, 16'h0000);
        end
        snd(16'h0477, 16'h0000);
        chk(action.outputs_on, 16'h0000);
        snd(16'h047f, 16'h0000);
        snd(16'h045f, 16'h0000);
        chk(action.hold, 16'h0001);
        snd(16'h044f, 16'h0000);
        chk(action.hold, 16'h0001);
        // Frozen output: only input trims move it, input brake stops it
        din_pins.speed_up = 1'b1;
        wt(6);
        chk(action.trim_up, 16'h0001);
        din_pins.speed_up = 1'b0;
        din_pins.dc_brake = 1'b1;
        ramp_done = 1'b0;
        wt(6);
        chk(action.stop_kind, STOP_BRAKE);
        din_pins.dc_brake = 1'b0;
        ramp_done = 1'b1;
        snd(16'h047f, 16'h0000);
        snd(16'h045f, 16'h0000);
        snd(16'h0457, 16'h0000);
        chk(action.outputs_on, 16'h0000);
        snd(16'h047f, 16'h0000);
        chk(action.ramp_set2, 16'h0000);
        snd(16'hff7f, 16'h0000);
        chk(action.jog, 16'h0001);
        chk(action.ramp_set2, 16'h0001);
        chk(action.setup_sel, 16'h0003);
        chk(action.reverse, 16'h0001);
        chk({action.relay1, action.relay2}, 16'h0003);
        cfg = '{REV_DIGITAL, 1'b0, 1'b1, 1'b0};
        snd(16'hff7f, 16'h0000);
        chk(action.reverse, 16'h0000);
        chk(action.relay1, 16'h0000);
        chk(action.setup_sel, 16'h0000);
        din_pins.reverse = 1'b1;
        cfg.rev_source = REV_AND;
        snd(16'h7f7f, 16'h0000);
        chk(action.reverse, 16'h0000);
        cfg.rev_source = REV_OR;
        wt(2);
        chk(action.reverse, 16'h0001);
        n_pulse = 0;
        snd(16'h04ff, 16'h0000);
        snd(16'h04ff, 16'h0000);
        chk(16'(n_pulse), 16'h0001);
        snd(16'h047f, 16'h0000);
        chk(16'(n_pulse), 16'h0001);
        status.drv_ready = 1'b1;
        status.warning = 1'b1;
        status.tripped = 1'b1;
        status.error_no_trip = 1'b1;
        status.trip_locked = 1'b1;
        status.overtemp_auto = 1'b1;
        status.dc_link_bad = 1'b1;
        status.torque_over = 1'b1;
        status.thermal_over = 1'b1;
        wt(3);
        chk(sw & 16'hf0ff, 16'hf0de);
        status = '0;
        status.ctrl_ready = 1'b1;
        output_freq = 16'h2000;
        wt(3);
        chk(sw & 16'hf0ff, 16'h0005);
        chk(sw[SW_IN_LIMIT], 16'h0001);
        chk(sw[SW_RUNNING], 16'h0001);
        chk(sw[SW_AT_REF], 16'h0001);
        ramp_done = 1'b0;
        output_freq = 16'h5000;
        wt(3);
        chk(sw[SW_IN_LIMIT], 16'h0000);
        chk(sw[SW_AT_REF], 16'h0000);
        chk(afv, 16'h5000);
        status.local_ref = 1'b1;
        wt(3);
        chk(sw[SW_BUS_CTRL], 16'h0000);
        snd(16'h0477, 16'h0100);
        chk(action.outputs_on, 16'h0001);
        chk(speed_ref_out, 16'h0000);
        status.local_ref = 1'b0;
        status.link_lost = 1'b1;
        wt(3);
        chk(sw, 16'h0000);
        chk(afv, 16'h0000);
        end_sim();
    end
endmodule
bind drive_bus_command_status_word drive_cmd_checker #(
    .SPEED_W(SPEED_W)
) drive_cmd_checker_i (
    .core_clk                      (core_clk),
    .reset                         (reset),
    .cmd_write                     (cmd_write),
    .command_word                  (command_word),
    .bus_speed_ref                 (bus_speed_ref),
    .state_report_word             (state_report_word),
    .actual_output_frequency_value (actual_output_frequency_value),
    .speed_ref_out                 (speed_ref_out),
    .status                        (status),
    .action                        (action),
    .trip_reset                    (trip_reset)
);

// ==== tb/drive_cmd_checker.sv ====
// Port-level assertions for the drive command/state block
`timescale 1ns/100ps
module drive_cmd_checker
    import drive_cmd_pkg::*;
#(
    parameter int SPEED_W = 16
) (
    // Clock and reset
    input wire logic                         core_clk,
    input wire logic                         reset,
    // Bus side
    input wire logic                         cmd_write,
    input wire logic [15:0]                  command_word,
    input wire logic [SPEED_W-1:0]           bus_speed_ref,
    input wire logic [15:0]                  state_report_word,
    input wire logic [SPEED_W-1:0]           actual_output_frequency_value,
    input wire logic [SPEED_W-1:0]           speed_ref_out,
    // Drive side
    input wire drive_cmd_pkg::drive_status_t status,
    input wire drive_cmd_pkg::drive_action_t action,
    input wire logic                         trip_reset
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic               acc;
    logic               rise;
    logic               b7_q, b7_d;
    logic [SPEED_W-1:0] ref_q, ref_d;
    assign acc = cmd_write && command_word[CW_VALID]
                 && !status.local_stop && !status.local_ref;
    // Edge is judged against the last accepted word only
    assign rise = acc && command_word[CW_RESET] && !b7_q;
    always_comb begin
        b7_d = acc ? command_word[CW_RESET] : b7_q;
        ref_d = acc ? bus_speed_ref : ref_q;
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            b7_q <= 1'b0;
            ref_q <= '0;
        end else begin
            b7_q <= b7_d;
            ref_q <= ref_d;
        end
    end
    sequence s_acc;
        acc;
    endsequence
    sequence s_coast;
        acc && !command_word[CW_NO_COAST];
    endsequence
    property p_spd;
        s_acc |=> ##[0:1] speed_ref_out == ref_q;
    endproperty
    a_spd: assert property (p_spd)
        else $error("speed reference not taken");
    property p_rst;
        rise |=> ##[0:1] trip_reset;
    endproperty
    a_rst: assert property (p_rst)
        else $error("trip reset missing after rising bit");
    property p_rstc;
        trip_reset |-> $past(rise) || $past(rise, 2);
    endproperty
    a_rstc: assert property (p_rstc)
        else $error("trip reset without rising bit");
    property p_res;
        state_report_word[SW_RESERVED] == 1'b0;
    endproperty
    a_res: assert property (p_res)
        else $error("reserved state bit set");
    property p_lost;
        status.link_lost |=> state_report_word == 16'h0000
            && actual_output_frequency_value == '0;
    endproperty
    a_lost: assert property (p_lost)
        else $error("state word not cleared on link loss");
    property p_trip;
        !status.link_lost |=>
            state_report_word[SW_TRIP] == $past(status.tripped);
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip bit wrong");
    property p_bus;
        !status.link_lost |=> state_report_word[SW_BUS_CTRL]
            == (!$past(status.local_stop) && !$past(status.local_ref));
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus control bit wrong");
    property p_coast;
        s_coast |=> ##[1:2] !action.outputs_on;
    endproperty
    a_coast: assert property (p_coast)
        else $error("outputs stay on after coast");
endmodule

// ==== verilog/din_sync.sv ====
// Three-stage synchroniser for asynchronous digital inputs
`timescale 1ns/100ps
module din_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Raw and settled inputs
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] out_d;

    always_comb begin
        out_d = out_q;
        // Take a new value only when stages two and three agree
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= raw_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule

// ==== verilog/drive_bus_command_status_word.sv ====
// Command word decoder and state report word builder for the drive
`timescale 1ns/100ps
module drive_bus_command_status_word #(
    parameter int SPEED_W = 16
) (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         reset,
    // Bus side words
    input  wire logic                         cmd_write,
    input  wire logic [15:0]                  command_word,
    input  wire logic [SPEED_W-1:0]           bus_speed_ref,
    output logic      [15:0]                  state_report_word,
    output logic      [SPEED_W-1:0]           actual_output_frequency_value,
    output logic      [SPEED_W-1:0]           speed_ref_out,
    // Drive configuration and state
    input  wire drive_cmd_pkg::drive_cfg_t    cfg,
    input  wire drive_cmd_pkg::drive_status_t status,
    input  wire logic [SPEED_W-1:0]           output_freq,
    input  wire logic [SPEED_W-1:0]           speed_low_limit,
    input  wire logic [SPEED_W-1:0]           speed_high_limit,
    input  wire logic                         ramp_done,
    // Digital input pins
    input  wire drive_cmd_pkg::din_func_t     din_pins,
    // Motor control actions
    output drive_cmd_pkg::drive_action_t      action,
    output logic                              trip_reset
);
    import drive_cmd_pkg::*;

    // Latched command word, updated only by valid words
    logic [15:0]   cw_q, cw_d;
    logic          rst_bit_q, rst_bit_d;
    logic          trip_reset_q, trip_reset_d;
    motion_state_t state_q, state_d;
    drive_action_t act_q, act_d;
    logic [15:0]   stw_q, stw_d;
    logic [SPEED_W-1:0] ref_q, ref_d, mav_q, mav_d;
    din_func_t     din;
    logic          start_ok, bus_ok, rev_cmd;

    din_sync #(
        .WIDTH($bits(din_func_t))
    ) u_din_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .raw_in   (din_pins),
        .sync_out (din)
    );

    function automatic logic signed_le(input logic [SPEED_W-1:0] a,
                                       input logic [SPEED_W-1:0] b);
        signed_le = $signed(a) <= $signed(b);
    endfunction

    // Bus control possible only without local stop or local reference
    assign bus_ok = !status.local_stop && !status.local_ref;

    // Command latch and reset edge
    always_comb begin
        cw_d         = cw_q;
        rst_bit_d    = rst_bit_q;
        trip_reset_d = 1'b0;
        // Invalid words and words under local control leave all unchanged
        if (cmd_write && command_word[CW_VALID] && bus_ok) begin
            cw_d      = command_word;
            rst_bit_d = command_word[CW_RESET];
            // Level alone never resets; only the rising edge does
            trip_reset_d = command_word[CW_RESET] && !rst_bit_q;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cw_q         <= COMMAND_WORD_RESET;
            rst_bit_q    <= 1'b0;
            trip_reset_q <= 1'b0;
        end else begin
            cw_q         <= cw_d;
            rst_bit_q    <= rst_bit_d;
            trip_reset_q <= trip_reset_d;
        end
    end

    // Reversal depends on the configured source
    always_comb begin
        case (cfg.rev_source)
            REV_BUS: rev_cmd = cw_q[CW_REVERSE];
            REV_AND: rev_cmd = cw_q[CW_REVERSE] && din.reverse;
            REV_OR:  rev_cmd = cw_q[CW_REVERSE] || din.reverse;
            default: rev_cmd = din.reverse;
        endcase
    end

    // Start needs every start-related bit high
    assign start_ok = cw_q[CW_NO_COAST] && cw_q[CW_NO_BRAKE]
                    && cw_q[CW_NO_QSTOP] && cw_q[CW_START]
                    && !status.tripped && !status.trip_locked
                    && !din.coast && !din.dc_brake && !din.reset_coast;

    // Motion state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (!cw_q[CW_NO_COAST] || din.coast || din.reset_coast) begin
                    state_d = ST_COAST;
                end else if (start_ok) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!cw_q[CW_NO_COAST] || din.coast || din.reset_coast) begin
                    state_d = ST_COAST;
                end else if (!cw_q[CW_NO_BRAKE] || !cw_q[CW_NO_QSTOP]
                             || !cw_q[CW_START] || din.dc_brake) begin
                    state_d = ST_STOP;
                end else if (!cw_q[CW_NO_HOLD]) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Frozen output ignores ramp and quick stop requests
                if (!cw_q[CW_NO_COAST] || din.coast || din.reset_coast) begin
                    state_d = ST_COAST;
                end else if (!cw_q[CW_NO_BRAKE] || din.dc_brake) begin
                    state_d = ST_STOP;
                end else if (cw_q[CW_NO_HOLD]) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (!cw_q[CW_NO_COAST] || din.coast || din.reset_coast) begin
                    state_d = ST_COAST;
                end else if (ramp_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_COAST: begin
                if (cw_q[CW_NO_COAST] && !din.coast && !din.reset_coast) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Action outputs
    always_comb begin
        act_d            = '0;
        act_d.outputs_on = (state_d != ST_COAST) && (state_d != ST_IDLE);
        act_d.run        = (state_d == ST_RUN) || (state_d == ST_HOLD);
        act_d.hold       = (state_d == ST_HOLD);
        act_d.trim_up    = act_d.hold && din.speed_up && !din.slow_down;
        act_d.trim_down  = act_d.hold && din.slow_down;
        if (state_d == ST_STOP) begin
            if (!cw_q[CW_NO_BRAKE] || din.dc_brake) begin
                act_d.stop_kind = STOP_BRAKE;
            end else if (!cw_q[CW_NO_QSTOP]) begin
                act_d.stop_kind = STOP_QUICK;
            end else begin
                act_d.stop_kind = STOP_RAMP;
            end
        end
        act_d.preset_sel = {cw_q[CW_PRESET_HI], cw_q[CW_PRESET_LO]};
        act_d.jog        = cw_q[CW_JOG];
        act_d.ramp_set2  = cw_q[CW_RAMP2];
        act_d.relay1     = cw_q[CW_RELAY1] && cfg.relay1_sel_bus;
        act_d.relay2     = cw_q[CW_RELAY2] && cfg.relay2_sel_bus;
        // Set-up stays at the first one unless multi-set-up is chosen
        act_d.setup_sel  = cfg.multi_setup
                         ? {cw_q[CW_SETUP_HI], cw_q[CW_SETUP_LO]}
                         : 2'h0;
        act_d.reverse    = rev_cmd;
    end

    // State report word
    always_comb begin
        stw_d                = '0;
        stw_d[SW_CTRL_READY] = status.ctrl_ready && !status.tripped;
        stw_d[SW_DRV_READY]  = status.drv_ready;
        stw_d[SW_ENABLE]     = act_q.outputs_on;
        stw_d[SW_TRIP]       = status.tripped;
        stw_d[SW_ERROR]      = status.error_no_trip;
        stw_d[SW_RESERVED]   = 1'b0;
        stw_d[SW_TRIP_LOCK]  = status.trip_locked;
        stw_d[SW_WARNING]    = status.warning;
        stw_d[SW_AT_REF]     = ramp_done && act_q.run;
        stw_d[SW_BUS_CTRL]   = bus_ok;
        stw_d[SW_IN_LIMIT]   = signed_le(speed_low_limit, output_freq)
                            && signed_le(output_freq, speed_high_limit);
        stw_d[SW_RUNNING]    = start_ok || (output_freq != '0);
        stw_d[SW_OVERTEMP]   = status.overtemp_auto;
        stw_d[SW_VOLTAGE]    = status.dc_link_bad;
        stw_d[SW_TORQUE]     = status.torque_over;
        stw_d[SW_TIMER]      = status.thermal_over;
        // A lost link must not report stale good status
        if (status.link_lost) begin
            stw_d = '0;
        end
    end

    // Speed words: same 16384 = 100 % scaling both ways, no rescaling
    always_comb begin
        ref_d = ref_q;
        if (cmd_write && command_word[CW_VALID] && bus_ok) begin
            ref_d = bus_speed_ref;
        end
        mav_d = status.link_lost ? '0 : output_freq;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            act_q   <= '0;
            stw_q   <= '0;
            ref_q   <= '0;
            mav_q   <= '0;
        end else begin
            state_q <= state_d;
            act_q   <= act_d;
            stw_q   <= stw_d;
            ref_q   <= ref_d;
            mav_q   <= mav_d;
        end
    end

    assign state_report_word             = stw_q;
    assign actual_output_frequency_value = mav_q;
    assign speed_ref_out                 = ref_q;
    assign action                        = act_q;
    assign trip_reset                    = trip_reset_q;
endmodule
